// ### verilog/wrc_wakeup_ctrl.sv
// Purpose: Always-on wake-up and reset controller on a 4 kHz tick.
// Assumes: Supply comparator gives a level; strap pins stable around release.
// Notes:   Everything else of the chip sits behind sys_power_on and sys_reset.
`timescale 1ns/1ps
module wrc_wakeup_ctrl
  import wrc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV             // Shorten in simulation.
) (
  input  wire logic              mclk,             // 125 MHz clock.
  input  wire logic              sys_rst,          // Synchronous reset, active high.
  input  wire logic              supply_low,       // Supply below release level.
  input  wire logic [1:0]        strap,            // Mode strap pins (pin1, pin0).
  input  wire wrc_bus_t          bus,              // Register port request.
  output logic [DATA_W-1:0]      rdata,            // Read data, cycle after read.
  input  wire wrc_wake_t         wake_in,          // Raw wake inputs.
  output logic                   sys_power_on,     // System controller supply.
  output logic                   sys_reset,        // System reset to core.
  output logic                   lf_rx_enable,     // LF receiver on.
  output logic                   overtemp_enable,  // Over-temperature detector on.
  output logic                   temp_ok_flag,     // Temperature below hot limit, or detector off.
  output logic [1:0]             op_mode           // Latched operating mode.
);

  localparam int SYNC_W = 10;                      // Width of the synchronised inputs.

  // All state of the controller in one word.
  typedef struct packed {
    wrc_state_t        st;                         // Power state.
    logic [1:0]        mode;                       // Latched operating mode.
    logic              strap_pend;                 // Mode capture pending.
    logic [2:0]        rst_cause;                  // Cause of last reset.
    logic [4:0]        wake_cause;                 // Sources of last wake.
    logic              div_sel;                    // Wake timer divides by 512.
    logic              lf_duty;                    // LF duty-cycle mode.
    logic              lf_wake;                    // LF wake enable.
    logic              tsd_en;                     // Thermal shutdown enable.
    logic              up_en;                      // Upper pin group enable.
    logic              lo_en;                      // Lower pin group enable.
    logic [1:0]        sel;                        // Wake pin selector.
    logic [3:0]        mask;                       // Blocks timer, carrier, pattern, pins.
    logic [15:0]       pwt;                        // Wake timer count.
    logic [7:0]        pwt_hi;                     // Staged high byte.
    logic [8:0]        pre;                        // Wake timer prescaler.
    logic              uf;                         // Underflow seen last cycle.
    logic [7:0]        lf_on;                      // LF on-time.
    logic [11:0]       lf_off;                     // LF off-time.
    logic [11:0]       lf_cnt;                     // Duty phase counter.
    logic              lf_phase;                   // High while LF is in its on phase.
    logic [TICK_W-1:0] tick_cnt;                   // 4 kHz tick divider.
    logic [7:0]        boot_cnt;                   // Boot sequence ticks.
    logic [SYNC_W-1:0] s1;                         // First synchroniser stage.
    logic [SYNC_W-1:0] s2;                         // Second synchroniser stage.
    logic [DATA_W-1:0] rdata;                      // Registered read data.
  } wrc_regs_t;

  wrc_regs_t  r_reg;                               // Present state.
  wrc_regs_t  r_next;                              // Next state.
  logic       full_rst;                            // Pin, power-on or brown-out reset.
  logic       tick;                                // One mclk cycle per 4 kHz period.
  logic       ptick;                               // Wake timer count step.
  logic       pwt_load;                            // Software loads the wake timer.
  logic       uf_now;                              // Wake timer underflows now.
  logic [5:0] pin_sel;                             // Pins chosen for wake.
  logic       pin_wake;                            // A chosen pin is low.
  logic [3:0] ev;                                  // Unmasked wake events.
  logic       rel_now;                             // Thermal release seen.
  logic       wr_ok;                               // Writes accepted while running.

  // Supply reset acts exactly like the pin reset.
  assign full_rst = sys_rst | supply_low;
  assign tick     = (r_reg.tick_cnt == TICK_W'(TICK_CYCLES - 1));
  assign ptick    = tick && (r_reg.pre == (r_reg.div_sel ? PRE_DIV512 : PRE_DIV8));
  assign wr_ok    = bus.wr && (r_reg.st == WRC_RUN);
  assign pwt_load = wr_ok && (bus.addr == A_PWT_LO);
  // A load wins over a step so a written zero never underflows at once.
  assign uf_now   = ptick && !pwt_load && (r_reg.pwt == 16'h0000);
  assign rel_now  = r_reg.s2[0];

  // Pin selection matrix from the two group enables and the selector.
  always_comb begin
    pin_sel = 6'h00;                               // Both enables off: no pin wake.
    if (r_reg.up_en && !r_reg.lo_en) begin
      case (r_reg.sel)
        2'h0:    pin_sel = 6'h01;
        2'h1:    pin_sel = 6'h02;
        2'h2:    pin_sel = 6'h10;
        default: pin_sel = 6'h23;
      endcase
    end else if (!r_reg.up_en && r_reg.lo_en) begin
      case (r_reg.sel)
        2'h0:    pin_sel = 6'h04;
        2'h1:    pin_sel = 6'h08;
        2'h2:    pin_sel = 6'h20;
        default: pin_sel = 6'h2C;
      endcase
    end else if (r_reg.up_en && r_reg.lo_en) begin
      case (r_reg.sel)
        2'h0:    pin_sel = 6'h05;
        2'h1:    pin_sel = 6'h0A;
        2'h2:    pin_sel = 6'h30;
        default: pin_sel = 6'h3F;
      endcase
    end
  end

  // Level test on synchronised pins; edges and high levels do nothing.
  assign pin_wake = |(pin_sel & ~r_reg.s2[9:4]);
  // Event vector order: pins, pattern, carrier, timer.
  assign ev = {pin_wake, r_reg.s2[2], r_reg.s2[3], uf_now} & ~r_reg.mask;

  // Next-state logic for the whole controller.
  always_comb begin
    r_next = r_reg;
    r_next.tick_cnt = tick ? '0 : r_reg.tick_cnt + 1'b1;
    r_next.uf = uf_now;
    r_next.rdata = '0;                             // Unmapped reads return zero.
    // Inputs are sampled once per tick and cross two stages.
    if (tick) begin
      r_next.s1 = {wake_in.gpio, wake_in.lf_carrier, wake_in.lf_pattern,
                   wake_in.temp_hot, wake_in.temp_release};
      r_next.s2 = r_reg.s1;
    end
    // Wake timer runs whatever the power state is.
    if (tick) begin
      r_next.pre = ptick ? 9'h000 : r_reg.pre + 9'h001;
    end
    if (pwt_load) begin
      r_next.pwt = {r_reg.pwt_hi, bus.wdata};
      r_next.pre = 9'h000;
    end else if (uf_now) begin
      r_next.pwt = PWT_RELOAD;
    end else if (ptick) begin
      r_next.pwt = r_reg.pwt - 16'h0001;
    end
    // LF duty timer; the counter stays internal.
    if (!(r_reg.lf_duty && r_reg.lf_wake)) begin
      r_next.lf_cnt = 12'h000;
      r_next.lf_phase = 1'b1;
    end else if (tick) begin
      if (r_reg.lf_phase && (r_reg.lf_cnt == {4'h0, r_reg.lf_on})) begin
        r_next.lf_cnt = 12'h000;
        r_next.lf_phase = 1'b0;
      end else if (!r_reg.lf_phase && (r_reg.lf_cnt == r_reg.lf_off)) begin
        r_next.lf_cnt = 12'h000;
        r_next.lf_phase = 1'b1;
      end else begin
        r_next.lf_cnt = r_reg.lf_cnt + 12'h001;
      end
    end
    // Register writes, only while the system is powered and running.
    if (wr_ok) begin
      if (bus.addr == A_CTRL) begin
        r_next.div_sel = bus.wdata[C_DIVSEL];
        r_next.lf_duty = bus.wdata[C_LFDUTY];
        r_next.lf_wake = bus.wdata[C_LFWAKE];
        r_next.tsd_en  = bus.wdata[C_TSDEN];
        // A new divider restarts the prescaler.
        if (bus.wdata[C_DIVSEL] != r_reg.div_sel) begin
          r_next.pre = 9'h000;
        end
      end else if (bus.addr == A_WAKECFG) begin
        r_next.up_en = bus.wdata[0];
        r_next.lo_en = bus.wdata[1];
        r_next.sel   = bus.wdata[3:2];
        r_next.mask  = bus.wdata[7:4];
      end else if (bus.addr == A_PWT_HI) begin
        r_next.pwt_hi = bus.wdata;
      end else if (bus.addr == A_LF_ON) begin
        r_next.lf_on = bus.wdata;
      end else if (bus.addr == A_LF_OFFL) begin
        r_next.lf_off[7:0] = bus.wdata;
      end else if (bus.addr == A_LF_OFFH) begin
        r_next.lf_off[11:8] = bus.wdata[3:0];
      end
    end
    // Register reads; no duty timer count is mapped.
    if (bus.rd) begin
      if (bus.addr == A_CTRL) begin
        r_next.rdata = {4'h0, r_reg.tsd_en, r_reg.lf_wake, r_reg.lf_duty, r_reg.div_sel};
      end else if (bus.addr == A_WAKECFG) begin
        r_next.rdata = {r_reg.mask, r_reg.sel, r_reg.lo_en, r_reg.up_en};
      end else if (bus.addr == A_PWT_LO) begin
        r_next.rdata = r_reg.pwt[7:0];
      end else if (bus.addr == A_PWT_HI) begin
        r_next.rdata = r_reg.pwt[15:8];
      end else if (bus.addr == A_LF_ON) begin
        r_next.rdata = r_reg.lf_on;
      end else if (bus.addr == A_LF_OFFL) begin
        r_next.rdata = r_reg.lf_off[7:0];
      end else if (bus.addr == A_LF_OFFH) begin
        r_next.rdata = {4'h0, r_reg.lf_off[11:8]};
      end else if (bus.addr == A_STATUS) begin
        r_next.rdata = {r_reg.rst_cause, r_reg.st, r_reg.mode, temp_ok_flag};
      end else if (bus.addr == A_CAUSE) begin
        r_next.rdata = {3'h0, r_reg.wake_cause};
      end
    end
    // Power state machine.
    case (r_reg.st)
      WRC_RUN: begin
        if (uf_now) begin
          r_next.st = WRC_BOOT;
          r_next.rst_cause = RC_PWT;
        end else if (wr_ok && bus.addr == A_CTRL && bus.wdata[C_SWRST]) begin
          r_next.st = WRC_BOOT;
          r_next.rst_cause = RC_SW;
        end else if (wr_ok && bus.addr == A_CTRL && bus.wdata[C_POWER_DOWN_REQUEST]) begin
          // Requested while temp_ok_flag is low, power-down becomes thermal shutdown.
          r_next.st = temp_ok_flag ? WRC_PWRDN : WRC_THERMAL;
        end
      end
      WRC_PWRDN: begin
        if (|ev) begin
          r_next.st = WRC_BOOT;
          r_next.rst_cause = RC_WAKE;
          r_next.wake_cause = {1'b0, ev};
        end
      end
      WRC_THERMAL: begin
        // Only the release threshold ends thermal shutdown.
        if (rel_now) begin
          r_next.st = WRC_BOOT;
          r_next.rst_cause = RC_WAKE;
          r_next.wake_cause = 5'h10;
        end
      end
      default: begin
        if (tick) begin
          r_next.boot_cnt = r_reg.boot_cnt + 8'h01;
        end
        if (r_reg.boot_cnt == BOOT_TICKS) begin
          r_next.st = WRC_RUN;
          r_next.boot_cnt = 8'h00;
        end
      end
    endcase
    // Entering boot reloads control bits to their wake-up values.
    if (r_next.st == WRC_BOOT && r_reg.st != WRC_BOOT) begin
      r_next.div_sel = 1'b0;
      r_next.lf_duty = 1'b0;
      r_next.lf_wake = 1'b0;
      r_next.tsd_en  = 1'b0;
      r_next.boot_cnt = 8'h00;
    end
    // Straps are read in the first cycle after a supply reset.
    if (r_reg.strap_pend) begin
      r_next.mode = strap;
      r_next.strap_pend = 1'b0;
    end
    // Supply reset clears everything and starts initialisation.
    if (full_rst) begin
      r_next = '0;
      r_next.st = WRC_BOOT;
      r_next.strap_pend = 1'b1;
      r_next.rst_cause = RC_POR;
      r_next.pwt = PWT_RELOAD;
      r_next.lf_phase = 1'b1;
      r_next.mask = 4'hF;
      r_next.s1 = '1;
      r_next.s2 = '1;
    end
  end

  // State register; reset is folded into the next-state logic.
  always_ff @(posedge mclk) begin
    r_reg <= r_next;
  end

  // Outputs toward the system controller and analog blocks.
  assign rdata = r_reg.rdata;
  assign sys_power_on = (r_reg.st == WRC_RUN) || (r_reg.st == WRC_BOOT);
  assign sys_reset = (r_reg.st == WRC_BOOT);
  assign lf_rx_enable = r_reg.lf_wake && (!r_reg.lf_duty || r_reg.lf_phase);
  assign overtemp_enable = r_reg.tsd_en || (r_reg.st == WRC_THERMAL);
  assign temp_ok_flag = !r_reg.tsd_en || !r_reg.s2[1];
  assign op_mode = r_reg.mode;

  // Checks placed beside the logic they guard.
  a_uf_reload: assert property (@(posedge mclk) disable iff (full_rst)
    uf_now |=> (r_reg.pwt == PWT_RELOAD) && r_reg.uf)
    else $error("Wake timer did not reload after underflow.");
  a_load_no_uf: assert property (@(posedge mclk) disable iff (full_rst)
    pwt_load |=> !r_reg.uf && (r_reg.pwt == {$past(r_reg.pwt_hi), $past(bus.wdata)}))
    else $error("Timer load produced an underflow.");
  a_pd_unpowered: assert property (@(posedge mclk) disable iff (full_rst)
    (r_reg.st == WRC_PWRDN) && !(|ev) |=> !sys_power_on)
    else $error("System powered without a wake event.");
  a_wake_boot: assert property (@(posedge mclk) disable iff (full_rst)
    (r_reg.st == WRC_PWRDN) && (|ev) |=> sys_reset && sys_power_on)
    else $error("Unmasked wake did not start boot.");
  a_mode_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    !full_rst && !r_reg.strap_pend && !$past(full_rst) |=> $stable(r_reg.mode))
    else $error("Mode changed without a supply reset.");
  a_strap_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(full_rst) |=> r_reg.mode == $past(strap))
    else $error("Mode not taken from straps at release.");
  a_thermal_hold: assert property (@(posedge mclk) disable iff (full_rst)
    (r_reg.st == WRC_THERMAL) && !rel_now |=> r_reg.st == WRC_THERMAL)
    else $error("Thermal shutdown left without release.");
  a_lf_steady: assert property (@(posedge mclk) disable iff (full_rst)
    !r_reg.lf_duty |-> lf_rx_enable == r_reg.lf_wake)
    else $error("LF duty timer ran while not enabled.");
  a_temp_flag: assert property (@(posedge mclk) disable iff (full_rst)
    !r_reg.tsd_en |-> temp_ok_flag)
    else $error("Temperature flag low while detector off.");
  a_pin_high: assert property (@(posedge mclk) disable iff (full_rst)
    (&r_reg.s2[9:4]) |-> !pin_wake)
    else $error("Pin wake from high levels.");

  // A plain step takes exactly one count off the wake timer.
  a_pwt_step: assert property (@(posedge mclk) disable iff (full_rst)
    ptick && !pwt_load && !uf_now |=> r_reg.pwt == $past(r_reg.pwt) - 16'h0001)
    else $error("Wake timer step was not one count.");

  // Without both LF bits the duty timer rests in its on phase at zero.
  a_lf_idle: assert property (@(posedge mclk) disable iff (full_rst)
    !(r_reg.lf_duty && r_reg.lf_wake) |=> r_reg.lf_phase && (r_reg.lf_cnt == 12'h000))
    else $error("LF duty timer moved while disabled.");

  // Control bits keep their wake-up values for the whole boot.
  a_boot_clean: assert property (@(posedge mclk) disable iff (full_rst)
    (r_reg.st == WRC_BOOT)
    |-> !(r_reg.div_sel || r_reg.lf_duty || r_reg.lf_wake || r_reg.tsd_en))
    else $error("Control bits not reloaded during boot.");

  // A software reset request starts boot with the software cause, unless the wake timer underflows in the same cycle.
  a_sw_boot: assert property (@(posedge mclk) disable iff (full_rst)
    wr_ok && (bus.addr == A_CTRL) && bus.wdata[C_SWRST] && !uf_now
    |=> sys_reset && (r_reg.rst_cause == RC_SW))
    else $error("Software reset did not start boot.");

  // A supply or pin reset always leaves the controller booting.
  a_reset_boot: assert property (@(posedge mclk)
    full_rst |=> sys_reset && (r_reg.rst_cause == RC_POR))
    else $error("Reset did not start boot with the supply cause.");

endmodule : wrc_wakeup_ctrl

// ### verilog/wrc_pkg.sv
// Purpose: Shared constants and carrier types of the wake-up reset controller.
// Assumes: 8-bit register port, 125 MHz mclk, 4 kHz low-frequency tick.
// Notes:   Offsets, fields, codes and timing counts live here only.
package wrc_pkg;
  localparam int DATA_W = 8;                       // Register data width.
  localparam int ADDR_W = 4;                       // Register address width.
  localparam int TICK_W = 16;                      // Width of the 4 kHz tick divider.
  localparam int CLK_PERIOD_NS = 8;                // Period of mclk in ns.
  localparam int LFO_PERIOD_NS = 250000;           // Period of the 4 kHz oscillator in ns.
  localparam int TICK_DIV = LFO_PERIOD_NS / CLK_PERIOD_NS;  // mclk cycles per tick.
  localparam logic [8:0]  PRE_DIV8   = 9'h007;     // Last prescaler count, divide by 8.
  localparam logic [8:0]  PRE_DIV512 = 9'h1FF;     // Last prescaler count, divide by 512.
  localparam logic [15:0] PWT_RELOAD = 16'hFFFF;   // Wake timer value after underflow.
  localparam logic [7:0]  BOOT_TICKS = 8'h04;      // Boot sequence length in ticks.
  // Register offsets.
  localparam logic [3:0] A_CTRL    = 4'h0;         // Control bits and commands.
  localparam logic [3:0] A_WAKECFG = 4'h1;         // Pin selection and wake masks.
  localparam logic [3:0] A_PWT_LO  = 4'h2;         // Wake timer low byte.
  localparam logic [3:0] A_PWT_HI  = 4'h3;         // Wake timer high byte.
  localparam logic [3:0] A_LF_ON   = 4'h4;         // LF on-time in ticks.
  localparam logic [3:0] A_LF_OFFL = 4'h5;         // LF off-time bits 7:0.
  localparam logic [3:0] A_LF_OFFH = 4'h6;         // LF off-time bits 11:8.
  localparam logic [3:0] A_STATUS  = 4'h7;         // Temperature, mode and reset cause.
  localparam logic [3:0] A_CAUSE   = 4'h8;         // Last wake cause.
  // Control register fields.
  localparam int C_DIVSEL = 0;                     // Wake timer divider select.
  localparam int C_LFDUTY = 1;                     // LF duty-cycle mode.
  localparam int C_LFWAKE = 2;                     // LF wake enable.
  localparam int C_TSDEN  = 3;                     // Thermal shutdown enable.
  localparam int C_POWER_DOWN_REQUEST   = 4;                     // Power-down request, write only.
  localparam int C_SWRST  = 5;                     // Software reset, write only.
  // Reset cause codes.
  localparam logic [2:0] RC_POR = 3'h1;            // Power-on or brown-out.
  localparam logic [2:0] RC_SW  = 3'h2;            // Software request.
  localparam logic [2:0] RC_PWT = 3'h3;            // Wake timer underflow.
  localparam logic [2:0] RC_WAKE = 3'h4;           // Ordinary wake-up.
  // Operating mode codes from the strap pins (pin1, pin0).
  localparam logic [1:0] MODE_DEBUG = 2'h1;        // Debug mode.
  localparam logic [1:0] MODE_PROG  = 2'h2;        // Programming mode.
  localparam logic [1:0] MODE_NORM  = 2'h3;        // Normal mode.
  // Controller states.
  typedef enum logic [1:0] {WRC_RUN, WRC_PWRDN, WRC_THERMAL, WRC_BOOT} wrc_state_t;
  // Register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wrc_bus_t;
  // Raw wake and sensor inputs from outside the 4 kHz domain.
  typedef struct packed {
    logic [5:0] gpio;                              // Pin levels, low level wakes.
    logic       lf_carrier;                        // LF carrier detected.
    logic       lf_pattern;                        // LF wake pattern matched.
    logic       temp_hot;                          // Above the hot threshold.
    logic       temp_release;                      // Below the hot release threshold.
  } wrc_wake_t;
endpackage : wrc_pkg

// ### verif/wrc_far_side.sv
// Purpose: Far-side model of wake pins, LF receiver and temperature sensor.
// Assumes: Pins carry pull-ups, so a pin nobody pulls down reads high.
// Notes:   The bench sets pin, LF event and heat levels.
`timescale 1ns/1ps
module wrc_far_side
  import wrc_pkg::*;
(
  input  wire logic [5:0] pin_low,  // Pins held low by an outside switch.
  input  wire logic       lf_car,   // LF receiver reports a carrier.
  input  wire logic       lf_pat,   // LF receiver reports a pattern match.
  input  wire logic       hot,      // Die above the hot threshold.
  output wrc_wake_t       wake      // Levels seen by the controller.
);
  // Released pins float up to the pull-up level, never to a stale value.
  assign wake.gpio         = ~pin_low;
  assign wake.lf_carrier   = lf_car;
  assign wake.lf_pattern   = lf_pat;
  assign wake.temp_hot     = hot;
  // Release only once cooled, so hot and release never stand together.
  assign wake.temp_release = ~hot;
endmodule : wrc_far_side

// ### verif/tb_wrc_wakeup_ctrl.sv
// Purpose: Self-checking bench of the wake-up reset controller.
// Assumes: Tick shortened to 4 mclk cycles; straps start in debug mode.
// Notes:   Each scenario task drives the block and judges the answer itself.
`timescale 1ns/1ps
module tb_wrc_wakeup_ctrl;
  import wrc_pkg::*;
  logic        mclk = 1'b0;      // Bench clock, 8 ns period.
  logic        sys_rst = 1'b1;   // Reset held at start.
  logic        supply_low = 1'b0; // Supply comparator level.
  logic [1:0]  strap = 2'h1;     // Straps select debug mode.
  wrc_bus_t    bus = '0;         // Register port request.
  logic [7:0]  rdata;            // Read data.
  wrc_wake_t   wake;             // Wake levels from the far side.
  logic [5:0]  pin_low = '0;     // Pins pulled low.
  logic        hot = 1'b0;       // Heat level.
  logic        lf_car = 1'b0;    // LF carrier level.
  logic        lf_pat = 1'b0;    // LF pattern level.
  localparam int TB_TICK = 4;    // mclk cycles per shortened tick.
  logic        pwr, srst, lfen, oten, tok;  // Controller outputs.
  logic [1:0]  mode;             // Latched mode.
  int          error_cnt = 0;    // Mismatches seen.
  int          comparisons = 0;  // Comparisons made.
  always #4 mclk = ~mclk;
  wrc_wakeup_ctrl #(.TICK_CYCLES(TB_TICK)) u_wrc_wakeup_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .supply_low(supply_low), .strap(strap), .bus(bus), .rdata(rdata), .wake_in(wake),
    .sys_power_on(pwr), .sys_reset(srst), .lf_rx_enable(lfen), .overtemp_enable(oten),
    .temp_ok_flag(tok), .op_mode(mode));
  wrc_far_side u_wrc_far_side (.pin_low(pin_low), .lf_car(lf_car), .lf_pat(lf_pat), .hot(hot),
    .wake(wake));
  // Compare one value and count it.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask : wr
  // One-cycle read, data compared in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd
  // Wait a bounded time for an output (0 reset, 1 power, 2 temp ok, 3 LF on) to reach v.
  task automatic wait_out(input int sel, input logic v, input string what);
    logic s;
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk) #1 s = (sel == 0) ? srst : (sel == 1) ? pwr : (sel == 2) ? tok : lfen;
      if (s === v) break;
    end
    chk(what, {7'h00, v}, {7'h00, s});
  endtask : wait_out
  // Pin reset latches straps, boots, and reports the supply cause.
  task automatic t_por;
    wait_out(0, 1'b0, "boot end");
    chk("mode", 8'h01, {6'h00, mode});
    rd(A_STATUS, 8'h23, "status por");
    rd(4'hF, 8'h00, "unmapped");
  endtask : t_por
  // Only the selected pin wakes, and only on low level.
  task automatic t_pin;
    wr(A_WAKECFG, 8'h71);
    wr(A_CTRL, 8'h10);
    wait_out(1, 1'b0, "pd entry");
    @(posedge mclk) pin_low <= 6'h02;
    repeat (60) @(posedge mclk);
    #1 chk("unselected pin", 8'h00, {7'h00, pwr});
    @(posedge mclk) pin_low <= 6'h01;
    wait_out(1, 1'b1, "pin wake");
    @(posedge mclk) pin_low <= 6'h00;
    wait_out(0, 1'b0, "boot after wake");
    rd(A_CAUSE, 8'h08, "wake cause");
    rd(A_STATUS, 8'h83, "status wake");
  endtask : t_pin
  // Software reset reboots but keeps the strap mode.
  task automatic t_sw;
    @(posedge mclk) strap <= 2'h2;
    wr(A_CTRL, 8'h20);
    wait_out(0, 1'b1, "sw reset");
    wait_out(0, 1'b0, "sw boot end");
    chk("mode kept", 8'h01, {6'h00, mode});
    rd(A_STATUS, 8'h43, "status sw");
  endtask : t_sw
  // Power down, raise one LF event until the system wakes, check the cause.
  task automatic lf_event_wake(input logic car, input logic [7:0] cause, input string what);
    wr(A_CTRL, 8'h10);
    wait_out(1, 1'b0, "lf pd entry");
    @(posedge mclk) begin
      lf_car <= car;
      lf_pat <= ~car;
    end
    wait_out(1, 1'b1, "lf wake");
    @(posedge mclk) begin
      lf_car <= 1'b0;
      lf_pat <= 1'b0;
    end
    wait_out(0, 1'b0, "lf boot end");
    rd(A_CAUSE, cause, what);
  endtask : lf_event_wake
  // Duty timer phase lengths, its enable pair, then carrier and pattern wakes.
  task automatic t_lf;
    int n;
    wr(A_LF_ON, 8'h01);
    wr(A_LF_OFFL, 8'h02);
    wr(A_LF_OFFH, 8'h00);
    wr(A_CTRL, 8'h06);
    #1 chk("lf on at enable", 8'h01, {7'h00, lfen});
    wait_out(3, 1'b0, "lf off phase");
    n = 0;
    while (lfen === 1'b0 && n < 100) begin
      @(posedge mclk) #1 n++;
    end
    chk("lf off cycles", 8'(3 * TB_TICK), 8'(n));
    n = 0;
    while (lfen === 1'b1 && n < 100) begin
      @(posedge mclk) #1 n++;
    end
    chk("lf on cycles", 8'(2 * TB_TICK), 8'(n));
    wr(A_CTRL, 8'h04);
    repeat (20) @(posedge mclk);
    #1 chk("lf steady on", 8'h01, {7'h00, lfen});
    wr(A_CTRL, 8'h02);
    #1 chk("lf duty no wake", 8'h00, {7'h00, lfen});
    wr(A_WAKECFG, 8'h90);
    lf_event_wake(1'b1, 8'h02, "carrier cause");
    lf_event_wake(1'b0, 8'h04, "pattern cause");
  endtask : t_lf
  // Wake timer wakes from power-down, then resets a running system.
  task automatic t_timer;
    wr(A_WAKECFG, 8'hE0);
    wr(A_PWT_HI, 8'h00);
    wr(A_PWT_LO, 8'h02);
    rd(A_PWT_LO, 8'h02, "timer load");
    wr(A_CTRL, 8'h10);
    wait_out(1, 1'b0, "timer pd entry");
    wait_out(1, 1'b1, "timer wake");
    wait_out(0, 1'b0, "timer boot end");
    rd(A_CAUSE, 8'h01, "timer cause");
    rd(A_PWT_HI, 8'hFF, "timer reload");
    wr(A_PWT_LO, 8'h02);
    wait_out(0, 1'b1, "timer reset");
    wait_out(0, 1'b0, "timer reset end");
    rd(A_STATUS, 8'h63, "status timer");
  endtask : t_timer
  // Heat clears temp ok, thermal shutdown waits for cooling, then wakes.
  task automatic t_thermal;
    wr(A_CTRL, 8'h08);
    hot <= 1'b1;
    wait_out(2, 1'b0, "temp ok low");
    wr(A_CTRL, 8'h18);
    wait_out(1, 1'b0, "thermal entry");
    repeat (60) @(posedge mclk);
    #1 chk("detector on", 8'h02, {6'h00, oten, pwr});
    @(posedge mclk) hot <= 1'b0;
    wait_out(1, 1'b1, "thermal wake");
    wait_out(0, 1'b0, "thermal boot end");
    rd(A_CAUSE, 8'h10, "thermal cause");
  endtask : t_thermal
  // Supply drop mid-run clears everything and takes the new strap mode.
  task automatic t_supply;
    @(posedge mclk) supply_low <= 1'b1;
    wait_out(0, 1'b1, "supply reset");
    repeat (2) @(posedge mclk);
    supply_low <= 1'b0;
    wait_out(0, 1'b0, "supply boot end");
    chk("mode resampled", 8'h02, {6'h00, mode});
    rd(A_STATUS, 8'h25, "status supply");
    rd(A_WAKECFG, 8'hF0, "wakecfg cleared");
  endtask : t_supply
  // Print the counts and the verdict, then stop.
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Main sequence: four cycles of reset, then each scenario in turn.
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_por();
    t_pin();
    t_sw();
    t_lf();
    t_timer();
    t_thermal();
    t_supply();
    print_verdict();
  end
  // Watchdog well beyond the several hundred cycles the scenarios need.
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_wrc_wakeup_ctrl
